// ---- src/bmseq_dev.sv ----
// Battery mode sequencer: supply tracking, mode machine and core registers
// Notes on behaviour
// - Supply present and PLL locked gives mission
// - Mission only with supply; battery modes without it, or sleep from mission
// - Supply below threshold clears supply good flag
// - Then battery power, interrupt, status field update
// - Mission to brownout never restarts the processor
// - Brownout plus request bit enters display/sleep
// - Compute engine runs in brownout until stopped
// - Brownout keeps PLL setting; software may slow
// - Supply return: mission, main power, interrupt
// - Software soft reset after mission return
// - Wake on battery lands in brownout only
// - Listed wake events return to brownout
// - Wake cause kept in readable register
// - NV RAM always kept; volatile RAM mission/brownout
// - Display mode PLL runs only with boost
// - Leaving display restarts processor, resets config
// - Status codes 000, 001, 010, 011
module bmseq_dev (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // Core register port
    bmseq_if.dev                         bus,
    // Comparator, lock and wake pins (asynchronous)
    input  wire logic                    main_above_3v0_i,
    input  wire logic                    core_ok_i,
    input  wire logic                    pll_lock_i,
    input  wire logic                    pushbutton_input_i,
    input  wire logic                    wake_segment_pin_a_i,
    input  wire logic                    wake_segment_pin_b_i,
    input  wire logic                    wake_segment_pin_c_i,
    input  wire logic                    rx_i,
    input  wire logic                    optical_receive_pin_i,
    input  wire logic                    wake_timer_i,
    // Display boost setting from the display block
    input  wire logic                    boost_en_i,
    // Mode and power controls
    output bmseq_pkg::bmseq_mode_t       mode_o,
    output logic                         battery_sel_o,
    output logic                         cpu_restart_o,
    output logic                         ce_run_o,
    output logic                         pll_run_o,
    output logic                         pll_fast_o,
    output logic [2:0]                   cpu_div_o,
    output logic                         vram_keep_o,
    output logic                         nvram_keep_o
);
    import bmseq_pkg::*;

    typedef struct packed {
        logic [IN_W-1:0]   s1;
        logic [IN_W-1:0]   s2;
        logic [IN_W-1:0]   s3;
        bmseq_mode_t       mode;
        logic              batt;
        logic              irq;
        logic              restart;
        logic              ce_run;
        logic              pll_run;
        logic              vram;
        logic              nvram;
        logic [7:0]        ctrl;
        logic [7:0]        clock_gen_config;
        logic [WAKE_W-1:0] cause;
        logic [7:0]        rdata;
        logic              rvalid;
    } bmseq_dev_st_t;

    localparam bmseq_dev_st_t ST_RST = '{
        s1: '0, s2: '0, s3: '0, mode: BM_BROWNOUT, batt: 1'b1,
        irq: 1'b0, restart: 1'b0, ce_run: 1'b0, pll_run: 1'b1,
        vram: 1'b1, nvram: 1'b1, ctrl: CTRL_RST, clock_gen_config: CLOCK_GEN_CONFIG_RST,
        cause: '0, rdata: '0, rvalid: 1'b0
    };

    bmseq_dev_st_t s_r;
    bmseq_dev_st_t s_nxt;

    // Power status code from supply, core level and mode
    function automatic logic [2:0] pstat(input logic good, input logic core,
                                         input bmseq_mode_t m);
        if (good) begin
            pstat = PS_GOOD;
        end else if (m == BM_MISSION) begin
            pstat = PS_LOW;
        end else if (core) begin
            pstat = PS_BAT_OK;
        end else begin
            pstat = PS_BAT_MARG;
        end
    endfunction

    logic [IN_W-1:0]   pins;
    logic              good;
    logic              lock;
    logic [WAKE_W-1:0] rise;
    logic [WAKE_W-1:0] wake_ev;

    // Pin vector: comparators and PLL lock high, then wake sources low
    assign pins = {main_above_3v0_i, core_ok_i, pll_lock_i, pushbutton_input_i,
                   wake_segment_pin_a_i, wake_segment_pin_b_i,
                   wake_segment_pin_c_i, rx_i, optical_receive_pin_i,
                   wake_timer_i};

    // Second synchroniser stage feeds all logic; third holds last value
    assign good    = s_r.s2[IX_MAIN];
    assign lock    = s_r.s2[IX_LOCK];
    assign rise    = s_r.s2[WAKE_W-1:0] & ~s_r.s3[WAKE_W-1:0];
    // Serial lines wake on any edge, the others on a rising edge
    assign wake_ev = {rise[6:3],
                      s_r.s2[2:1] ^ s_r.s3[2:1],
                      rise[0]};

    // Next state: registers, mode machine and derived controls
    always_comb begin
        s_nxt         = s_r;
        s_nxt.s1      = pins;
        s_nxt.s2      = s_r.s1;
        s_nxt.s3      = s_r.s2;
        s_nxt.irq     = 1'b0;
        s_nxt.restart = 1'b0;
        s_nxt.rvalid  = 1'b0;
        s_nxt.nvram   = 1'b1;

        // Register writes from the core
        if (bus.reg_wr) begin
            if (bus.reg_addr == CTRL_ADDR) begin
                s_nxt.ctrl = bus.reg_wdata;
            end else if (bus.reg_addr == CLOCK_GEN_CONFIG_ADDR) begin
                s_nxt.clock_gen_config = bus.reg_wdata;
            end
        end

        // Register reads answer on the next cycle; cause clears on read
        if (bus.reg_rd) begin
            s_nxt.rvalid = 1'b1;
            if (bus.reg_addr == PWR_STATUS_ADDR) begin
                s_nxt.rdata = {5'h00, pstat(good, s_r.s2[IX_CORE], s_r.mode)};
            end else if (bus.reg_addr == CTRL_ADDR) begin
                s_nxt.rdata = s_r.ctrl;
            end else if (bus.reg_addr == CLOCK_GEN_CONFIG_ADDR) begin
                s_nxt.rdata = s_r.clock_gen_config;
            end else if (bus.reg_addr == CAUSE_ADDR) begin
                s_nxt.rdata = {1'b0, s_r.cause};
                s_nxt.cause = '0;
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end

        // Soft reset from software restores volatile settings
        if (bus.soft_rst) begin
            s_nxt.ctrl = CTRL_RST;
            s_nxt.clock_gen_config = CLOCK_GEN_CONFIG_RST;
        end

        // Mode machine
        unique case (s_r.mode)
            BM_MISSION: begin
                if (!good) begin
                    // Processor keeps running across this change
                    s_nxt.mode = BM_BROWNOUT;
                    s_nxt.batt = 1'b1;
                    s_nxt.irq  = 1'b1;
                end else if (s_r.ctrl[CTRL_SLEEP_BIT]) begin
                    // Sleep with supply present: wake follows at once
                    s_nxt.mode                 = BM_SLEEP;
                    s_nxt.ctrl[CTRL_SLEEP_BIT] = 1'b0;
                end
                // Display request only counts from brownout
                s_nxt.ctrl[CTRL_DISP_BIT] = 1'b0;
            end
            BM_BROWNOUT: begin
                if (good && lock) begin
                    s_nxt.mode = BM_MISSION;
                    s_nxt.batt = 1'b0;
                    s_nxt.irq  = 1'b1;
                end else if (s_r.ctrl[CTRL_SLEEP_BIT]) begin
                    s_nxt.mode                 = BM_SLEEP;
                    s_nxt.ctrl[CTRL_SLEEP_BIT] = 1'b0;
                    s_nxt.ctrl[CTRL_DISP_BIT]  = 1'b0;
                end else if (s_r.ctrl[CTRL_DISP_BIT]) begin
                    s_nxt.mode                = BM_DISPLAY;
                    s_nxt.ctrl[CTRL_DISP_BIT] = 1'b0;
                end
            end
            BM_DISPLAY, BM_SLEEP: begin
                if (good && lock) begin
                    // Supply return wins over a coincident wake
                    s_nxt.mode    = BM_MISSION;
                    s_nxt.batt    = 1'b0;
                    s_nxt.irq     = 1'b1;
                    s_nxt.restart = 1'b1;
                    s_nxt.ctrl    = CTRL_RST;
                    s_nxt.clock_gen_config    = CLOCK_GEN_CONFIG_RST;
                end else if (|wake_ev) begin
                    s_nxt.mode    = BM_BROWNOUT;
                    s_nxt.cause   = s_nxt.cause | wake_ev;
                    s_nxt.restart = 1'b1;
                    s_nxt.ctrl    = CTRL_RST;
                    s_nxt.clock_gen_config    = CLOCK_GEN_CONFIG_RST;
                end
            end
        endcase

        // Power controls follow the next mode
        s_nxt.ce_run = (s_nxt.mode == BM_MISSION || s_nxt.mode == BM_BROWNOUT)
                       && s_nxt.ctrl[CTRL_CE_BIT];
        s_nxt.vram   = (s_nxt.mode == BM_MISSION || s_nxt.mode == BM_BROWNOUT);
        unique case (s_nxt.mode)
            BM_DISPLAY: s_nxt.pll_run = boost_en_i;
            BM_SLEEP:   s_nxt.pll_run = 1'b0;
            BM_MISSION, BM_BROWNOUT: s_nxt.pll_run = 1'b1;
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign bus.reg_rdata  = s_r.rdata;
    assign bus.reg_rvalid = s_r.rvalid;
    assign bus.irq        = s_r.irq;
    assign mode_o         = s_r.mode;
    assign battery_sel_o  = s_r.batt;
    assign cpu_restart_o  = s_r.restart;
    assign ce_run_o       = s_r.ce_run;
    assign pll_run_o      = s_r.pll_run;
    assign pll_fast_o     = s_r.clock_gen_config[CLOCK_GEN_CONFIG_FAST_BIT];
    assign cpu_div_o      = s_r.clock_gen_config[2:0];
    assign vram_keep_o    = s_r.vram;
    assign nvram_keep_o   = s_r.nvram;

endmodule

// ---- src/bmseq_pkg.sv ----
// Shared constants and types for the battery mode sequencer and its controller
package bmseq_pkg;

    // Operating modes
    typedef enum logic [1:0] {
        BM_MISSION  = 2'b00,
        BM_BROWNOUT = 2'b01,
        BM_DISPLAY  = 2'b10,
        BM_SLEEP    = 2'b11
    } bmseq_mode_t;

    // Device register addresses on the core register port
    localparam logic [15:0] PWR_STATUS_ADDR = 16'h00F9;
    localparam logic [15:0] CTRL_ADDR       = 16'h28B2;
    localparam logic [15:0] CAUSE_ADDR      = 16'h28B3;
    localparam logic [15:0] CLOCK_GEN_CONFIG_ADDR       = 16'h2200;

    // Control register fields and reset values
    localparam int unsigned CTRL_SLEEP_BIT = 7;
    localparam int unsigned CTRL_DISP_BIT  = 6;
    localparam int unsigned CTRL_CE_BIT    = 0;
    localparam logic [7:0]  CTRL_RST       = 8'h01;
    localparam logic [7:0]  CLOCK_GEN_CONFIG_RST       = 8'h10;
    localparam logic [7:0]  CLOCK_GEN_CONFIG_SLOW      = 8'h24;
    localparam int unsigned CLOCK_GEN_CONFIG_FAST_BIT  = 4;

    // Power status codes
    localparam logic [2:0] PS_GOOD     = 3'h0;
    localparam logic [2:0] PS_LOW      = 3'h1;
    localparam logic [2:0] PS_BAT_OK   = 3'h2;
    localparam logic [2:0] PS_BAT_MARG = 3'h3;

    // Pin vector positions; wake cause bits use the low seven
    localparam int unsigned IN_W    = 10;
    localparam int unsigned IX_MAIN = 9;
    localparam int unsigned IX_CORE = 8;
    localparam int unsigned IX_LOCK = 7;
    localparam int unsigned WAKE_W  = 7;

    // Controller APB register offsets
    localparam logic [11:0] OFF_CMD   = 12'h000;
    localparam logic [11:0] OFF_STAT  = 12'h004;
    localparam logic [11:0] OFF_ISTAT = 12'h008;
    localparam logic [11:0] OFF_IMASK = 12'h00C;

    // Command bits and pending operation slots
    localparam int unsigned CMD_DISP  = 0;
    localparam int unsigned CMD_SLEEP = 1;
    localparam int unsigned CMD_SLOW  = 2;
    localparam int unsigned CMD_SRST  = 3;
    localparam int unsigned CMD_CEOFF = 4;
    localparam int unsigned OP_W      = 5;
    localparam int unsigned OP_CTRL   = 0;
    localparam int unsigned OP_CLOCK_GEN_CONFIG   = 1;
    localparam int unsigned OP_SRST   = 2;
    localparam int unsigned OP_STAT   = 3;
    localparam int unsigned OP_CAUSE  = 4;

endpackage

// ---- src/bmseq_if.sv ----
// Core register port between the sequencer and the microcontroller side
interface bmseq_if;
    logic [15:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic        soft_rst;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        irq;

    modport dev (
        input  reg_addr, reg_wr, reg_rd, reg_wdata, soft_rst,
        output reg_rdata, reg_rvalid, irq
    );

    modport host (
        output reg_addr, reg_wr, reg_rd, reg_wdata, soft_rst,
        input  reg_rdata, reg_rvalid, irq
    );
endinterface

// ---- src/bmseq_host.sv ----
// Microcontroller-side controller: APB registers driving the core port
module bmseq_host (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq_o,
    // Core register port
    bmseq_if.host            bus
);
    import bmseq_pkg::*;

    typedef enum logic [0:0] {
        H_IDLE = 1'b0,
        H_WAIT = 1'b1
    } bmseq_hst_t;

    typedef struct packed {
        bmseq_hst_t       st;
        logic [OP_W-1:0]  pend;
        logic [15:0]      addr;
        logic             wr;
        logic             rd;
        logic [7:0]       wdata;
        logic             srst;
        logic [7:0]       ctrl;
        logic [2:0]       pstat;
        logic [7:0]       cause;
        logic [1:0]       istat;
        logic [1:0]       imask;
        logic             irq;
        logic [31:0]      prdata;
        logic             pready;
    } bmseq_host_st_t;

    localparam bmseq_host_st_t ST_RST = '{
        st: H_IDLE, pend: '0, addr: '0, wr: 1'b0, rd: 1'b0, wdata: '0,
        srst: 1'b0, ctrl: CTRL_RST, pstat: '0, cause: '0, istat: '0,
        imask: '0, irq: 1'b0, prdata: '0, pready: 1'b0
    };

    bmseq_host_st_t h_r;
    bmseq_host_st_t h_nxt;
    logic [1:0]     ev;
    logic           acc;

    assign acc = psel && penable && h_r.pready;

    // Next state: APB slave, operation issue and interrupt bits
    always_comb begin
        h_nxt        = h_r;
        h_nxt.wr     = 1'b0;
        h_nxt.rd     = 1'b0;
        h_nxt.srst   = 1'b0;
        h_nxt.pready = psel && !penable;
        ev           = {1'b0, bus.irq};

        // Setup cycle prepares read data; access edge commits writes
        if (psel && !penable) begin
            unique case (paddr)
                OFF_STAT:  h_nxt.prdata = {8'h00, 7'h00, h_r.st == H_WAIT,
                                           h_r.cause, 5'h00, h_r.pstat};
                OFF_ISTAT: h_nxt.prdata = {30'h0, h_r.istat};
                OFF_IMASK: h_nxt.prdata = {30'h0, h_r.imask};
                default:   h_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (acc && pwrite) begin
            if (paddr == OFF_CMD) begin
                if (pwdata[CMD_DISP]) begin
                    h_nxt.ctrl[CTRL_DISP_BIT] = 1'b1;
                    h_nxt.pend[OP_CTRL]       = 1'b1;
                end
                if (pwdata[CMD_SLEEP]) begin
                    h_nxt.ctrl[CTRL_SLEEP_BIT] = 1'b1;
                    h_nxt.pend[OP_CTRL]        = 1'b1;
                end
                if (pwdata[CMD_CEOFF]) begin
                    h_nxt.ctrl[CTRL_CE_BIT] = 1'b0;
                    h_nxt.pend[OP_CTRL]     = 1'b1;
                end
                if (pwdata[CMD_SLOW]) begin
                    h_nxt.pend[OP_CLOCK_GEN_CONFIG] = 1'b1;
                end
                if (pwdata[CMD_SRST]) begin
                    h_nxt.pend[OP_SRST] = 1'b1;
                end
            end else if (paddr == OFF_IMASK) begin
                h_nxt.imask = pwdata[1:0];
            end
        end

        // Supply change interrupt: fetch status and wake cause
        if (bus.irq) begin
            h_nxt.pend[OP_STAT]  = 1'b1;
            h_nxt.pend[OP_CAUSE] = 1'b1;
        end

        // One core port operation at a time, lowest slot first
        unique case (h_r.st)
            H_IDLE: begin
                if (h_r.pend[OP_CTRL]) begin
                    h_nxt.pend[OP_CTRL] = 1'b0;
                    h_nxt.addr  = CTRL_ADDR;
                    h_nxt.wdata = h_nxt.ctrl;
                    h_nxt.wr    = 1'b1;
                    h_nxt.ctrl[CTRL_SLEEP_BIT] = 1'b0;
                    h_nxt.ctrl[CTRL_DISP_BIT]  = 1'b0;
                end else if (h_r.pend[OP_CLOCK_GEN_CONFIG]) begin
                    h_nxt.pend[OP_CLOCK_GEN_CONFIG] = 1'b0;
                    h_nxt.addr  = CLOCK_GEN_CONFIG_ADDR;
                    h_nxt.wdata = CLOCK_GEN_CONFIG_SLOW;
                    h_nxt.wr    = 1'b1;
                end else if (h_r.pend[OP_SRST]) begin
                    h_nxt.pend[OP_SRST] = 1'b0;
                    h_nxt.srst = 1'b1;
                    h_nxt.ctrl = CTRL_RST;
                end else if (h_r.pend[OP_STAT] || h_r.pend[OP_CAUSE]) begin
                    h_nxt.addr = h_r.pend[OP_STAT] ? PWR_STATUS_ADDR : CAUSE_ADDR;
                    h_nxt.rd   = 1'b1;
                    h_nxt.st   = H_WAIT;
                end
            end
            H_WAIT: begin
                if (bus.reg_rvalid) begin
                    h_nxt.st = H_IDLE;
                    ev[1]    = 1'b1;
                    if (h_r.addr == PWR_STATUS_ADDR) begin
                        h_nxt.pstat          = bus.reg_rdata[2:0];
                        h_nxt.pend[OP_STAT]  = 1'b0;
                    end else begin
                        h_nxt.cause          = bus.reg_rdata;
                        h_nxt.pend[OP_CAUSE] = 1'b0;
                    end
                end
            end
        endcase

        // Sticky status: write one clears, a new event wins
        if (acc && pwrite && paddr == OFF_ISTAT) begin
            h_nxt.istat = h_r.istat & ~pwdata[1:0];
        end
        h_nxt.istat = h_nxt.istat | ev;
        h_nxt.irq   = |(h_nxt.istat & h_nxt.imask);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            h_r <= ST_RST;
        end else begin
            h_r <= h_nxt;
        end
    end

    // Outputs straight from the state register; pslverr tied low
    assign prdata        = h_r.prdata;
    assign pready        = h_r.pready;
    assign pslverr       = 1'b0;
    assign irq_o         = h_r.irq;
    assign bus.reg_addr  = h_r.addr;
    assign bus.reg_wr    = h_r.wr;
    assign bus.reg_rd    = h_r.rd;
    assign bus.reg_wdata = h_r.wdata;
    assign bus.soft_rst  = h_r.srst;

endmodule

// ---- testbench/bmseq_checker.sv ----
// Concurrent checks on the core port and the mode outputs
module bmseq_checker (
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_n_i,
    // Core port and device outputs
    input wire logic                   reg_rd,
    input wire logic                   reg_rvalid,
    input wire logic                   irq,
    input wire bmseq_pkg::bmseq_mode_t mode_o,
    input wire logic                   battery_sel_o,
    input wire logic                   cpu_restart_o,
    input wire logic                   vram_keep_o,
    input wire logic                   nvram_keep_o
);
    import bmseq_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Mission dropped to brownout at this edge
    sequence s_to_brn;
        $past(mode_o) == BM_MISSION && mode_o == BM_BROWNOUT;
    endsequence
    // Display or sleep was left at this edge
    sequence s_wake;
        $past(mode_o) inside {BM_DISPLAY, BM_SLEEP} && mode_o != $past(mode_o);
    endsequence
    chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("core read not answered next cycle");
    chk_irq_pulse: assert property (irq |=> !irq)
        else $error("device interrupt longer than one cycle");
    chk_loss_steps: assert property (s_to_brn |-> irq && battery_sel_o)
        else $error("supply loss without battery switch and interrupt");
    chk_no_halt: assert property (s_to_brn |-> !cpu_restart_o)
        else $error("processor restarted on brownout entry");
    chk_mission_main: assert property (mode_o == BM_MISSION |-> !battery_sel_o)
        else $error("mission mode while on battery");
    chk_return_irq: assert property ($fell(battery_sel_o) |-> irq && mode_o == BM_MISSION)
        else $error("supply return without mission and interrupt");
    chk_wake_restart: assert property (s_wake |-> cpu_restart_o)
        else $error("no processor restart on leaving display or sleep");
    chk_display_entry: assert property ($rose(mode_o == BM_DISPLAY)
        |-> $past(mode_o) == BM_BROWNOUT)
        else $error("display mode entered from other than brownout");
    chk_ram_keep: assert property (nvram_keep_o
        && vram_keep_o == (mode_o inside {BM_MISSION, BM_BROWNOUT}))
        else $error("memory retention wrong for mode");
    chk_sleep_return: assert property ($past(mode_o) == BM_MISSION && mode_o == BM_SLEEP
        |=> mode_o == BM_MISSION && cpu_restart_o)
        else $error("sleep with supply present did not wake at once");
endmodule

// ---- testbench/tb.sv ----
// Testbench joining the sequencer and its controller over the core port
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bmseq_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        irq_o;
    logic        main_i = 1'b0;
    logic        lock_i = 1'b0;
    logic        boost = 1'b0;
    logic [6:0]  wk = 7'h00;
    bmseq_mode_t mode;
    logic        bsel, rst_cpu, ce_run, pll_run, pll_fast, vram, nvram;
    logic [2:0]  cpu_div;
    logic [31:0] q;
    int          err_count = 0;
    int          tests_run = 0;
    // Design ends and checker
    bmseq_if bus_if ();
    bmseq_dev bmseq_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if.dev),
        .main_above_3v0_i(main_i), .core_ok_i(1'b1), .pll_lock_i(lock_i),
        .pushbutton_input_i(wk[6]), .wake_segment_pin_a_i(wk[5]),
        .wake_segment_pin_b_i(wk[4]), .wake_segment_pin_c_i(wk[3]), .rx_i(wk[2]),
        .optical_receive_pin_i(wk[1]), .wake_timer_i(wk[0]), .boost_en_i(boost),
        .mode_o(mode), .battery_sel_o(bsel), .cpu_restart_o(rst_cpu), .ce_run_o(ce_run),
        .pll_run_o(pll_run), .pll_fast_o(pll_fast), .cpu_div_o(cpu_div),
        .vram_keep_o(vram), .nvram_keep_o(nvram));
    bmseq_host bmseq_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .irq_o(irq_o), .bus(bus_if.host));
    bmseq_checker bmseq_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_rd(bus_if.reg_rd), .reg_rvalid(bus_if.reg_rvalid), .irq(bus_if.irq),
        .mode_o(mode), .battery_sel_o(bsel), .cpu_restart_o(rst_cpu),
        .vram_keep_o(vram), .nvram_keep_o(nvram));
    // Clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wait_mode(input bmseq_mode_t m);
        for (int n = 0; n < 60 && mode !== m; n++) @(posedge clk_i);
    endtask
    task automatic t_reset();
        check("mode", 32'(mode), 32'(BM_BROWNOUT));
        check("battery", 32'(bsel), 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", q, 32'h0);
        apb(1'b0, OFF_IMASK, 32'h0);
        check("imask", q, 32'h0);
    endtask
    task automatic t_power_up();
        main_i <= 1'b1;
        lock_i <= 1'b1;
        wait_mode(BM_MISSION);
        check("mission", 32'(mode), 32'(BM_MISSION));
        apb(1'b1, OFF_CMD, 32'h1);
        cycles(10);
        check("disp ignored", 32'(mode), 32'(BM_MISSION));
    endtask
    task automatic t_loss();
        // Drop the event left from power-up before unmasking
        apb(1'b1, OFF_ISTAT, 32'h3);
        apb(1'b1, OFF_IMASK, 32'h1);
        main_i <= 1'b0;
        for (int n = 0; n < 60 && irq_o !== 1'b1; n++) @(posedge clk_i);
        check("irq", 32'(irq_o), 32'h1);
        check("brownout", 32'(mode), 32'(BM_BROWNOUT));
        check("pll fast", 32'(pll_fast), 32'h1);
        check("ce run", 32'(ce_run), 32'h1);
        apb(1'b1, OFF_ISTAT, 32'h1);
        cycles(2);
        check("irq clr", 32'(irq_o), 32'h0);
        for (int n = 0; n < 20 && q[2:0] !== PS_BAT_OK; n++) apb(1'b0, OFF_STAT, 32'h0);
        check("pstat", 32'(q[2:0]), 32'(PS_BAT_OK));
        apb(1'b1, OFF_CMD, 32'h14);
        cycles(6);
        check("pll slow", 32'(pll_fast), 32'h0);
        check("div", 32'(cpu_div), 32'h4);
        check("ce off", 32'(ce_run), 32'h0);
    endtask
    task automatic t_wakes();
        bmseq_mode_t m;
        for (int i = 0; i < 7; i++) begin
            m = i[0] ? BM_SLEEP : BM_DISPLAY;
            boost <= i[1];
            apb(1'b1, OFF_CMD, i[0] ? 32'h2 : 32'h1);
            wait_mode(m);
            check("enter", 32'(mode), 32'(m));
            if (!i[0]) check("pll boost", 32'(pll_run), 32'(i[1]));
            wk[i] <= 1'b1;
            wait_mode(BM_BROWNOUT);
            check("wake", 32'(mode), 32'(BM_BROWNOUT));
            wk[i] <= 1'b0;
            cycles(4);
        end
    endtask
    task automatic t_return();
        apb(1'b1, OFF_IMASK, 32'h0);
        apb(1'b1, OFF_CMD, 32'h4);
        cycles(4);
        check("slow", 32'(pll_fast), 32'h0);
        apb(1'b1, OFF_CMD, 32'h2);
        wait_mode(BM_SLEEP);
        main_i <= 1'b1;
        wk[6] <= 1'b1;
        wait_mode(BM_MISSION);
        check("return", 32'(mode), 32'(BM_MISSION));
        check("restart cfg", 32'(pll_fast), 32'h1);
        cycles(3);
        check("masked", 32'(irq_o), 32'h0);
        apb(1'b0, OFF_ISTAT, 32'h0);
        check("istat", 32'(q[0]), 32'h1);
        wk[6] <= 1'b0;
        // Every wake source was used once while on battery
        cycles(6);
        apb(1'b0, OFF_STAT, 32'h0);
        check("cause", 32'(q[14:8]), 32'h7F);
        check("pstat good", 32'(q[2:0]), 32'(PS_GOOD));
        apb(1'b1, OFF_CMD, 32'h14);
        cycles(6);
        check("ce stop", 32'(ce_run), 32'h0);
        apb(1'b1, OFF_CMD, 32'h8);
        cycles(6);
        check("cfg reset", 32'(pll_fast), 32'h1);
        check("ce reset", 32'(ce_run), 32'h1);
        // Sleep with supply present wakes straight back
        apb(1'b1, OFF_CMD, 32'h2);
        wait_mode(BM_SLEEP);
        check("sleep", 32'(mode), 32'(BM_SLEEP));
        wait_mode(BM_MISSION);
        check("sleep wake", 32'(mode), 32'(BM_MISSION));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        cycles(20000);
        err_count++;
        finish_test();
    end
    // Main sequence
    initial begin
        cycles(2);
        rst_n_i <= 1'b1;
        cycles(1);
        t_reset();
        t_power_up();
        t_loss();
        t_wakes();
        t_return();
        finish_test();
    end
endmodule
